// file: pkg/ext_bus_consts.svh
// Constants for the external bus host handshake block.
// Assumes inclusion by the package and design files by bare name.
`ifndef EXT_BUS_CONSTS_SVH
`define EXT_BUS_CONSTS_SVH
`define NUM_MP_REQ      6
`define PROC_NUM_W      3
`define PROC_NUM_SINGLE 3'h0
`define RESET_OWNER     3'h1
`endif

// file: pkg/ext_bus_pkg.sv
// Types for the external bus host handshake block.
// Assumes the constants header is on the include path.
`include "ext_bus_consts.svh"
package ext_bus_pkg;
   typedef enum logic [4:0] {
      ST_IDLE    = 5'h01,
      ST_REQ     = 5'h02,
      ST_MASTER  = 5'h04,
      ST_RELEASE = 5'h08,
      ST_HOSTGNT = 5'h10
   } bus_state_e;
   typedef struct packed {
      logic req_oe;
      logic grant_out;
      logic grant_oe;
      logic ack_out;
      logic ack_oe;
      logic ready_out;
      logic ready_oe;
      logic bus_oe;
      logic stall;
   } pin_out_s;
endpackage

// file: hw/mp_priority.sv
// Arbitration among multiprocessor bus requests, fixed or rotating.
// Assumes active-high request vector; bit 0 stands for line one.
`timescale 1ns/1ps
`default_nettype none
module mp_priority #(
   parameter int N = 6
) (
   // Inputs
   input  wire logic [N-1:0] req,
   input  wire logic [N-1:0] last_owner,
   input  wire logic         rotate,
   // Result
   output logic [N-1:0]      winner
);
   if (N < 2 || N > 7) begin : g_n_check
      $error("N out of range.");
   end
   logic [N-1:0] start;
   logic         found;
   int           idx;
   always_comb begin
      winner = '0;
      found  = 1'b0;
      start  = rotate ? {last_owner[N-2:0], last_owner[N-1]}
                      : {{(N-1){1'b0}}, 1'b1};
      idx    = 0;
      for (int i = 0; i < N; i++) begin
         if (start[i]) begin
            idx = i;
         end
      end
      for (int k = 0; k < N; k++) begin
         if (!found && req[(idx + k) % N]) begin
            winner[(idx + k) % N] = 1'b1;
            found = 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// file: hw/ext_bus_ctrl.sv
// Shared external bus control: host request/grant, wait states, suspend.
// Assumes all inputs synchronous to core_clk; pins resolved outside.
`include "ext_bus_consts.svh"
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Device pulls acknowledge low during synchronous internal access until ready.
// - Slave pulls master acknowledge low for internal-memory wait states.
// - Bus master keeps acknowledge at last driven level with a keeper.
// - Suspend sampled low three-states address, data, selects, strobes next cycle.
// - External access attempted under suspend stalls until suspend released.
// - Owner on host request three-states bus, then asserts grant.
// - Host request beats every multiprocessor request.
// - Grant held low until host withdraws its request.
// - Only bus master drives grant; others monitor it (no logic here reads host_bus_grant_n_in).
// - Ready held low during async host access until it can finish.
// - Ready open-drain by default, active drive when mode bit set.
// - Ready driven only while chip select and host request both asserted.
// - Drive only own request line; sample others for arbitration.
// - Bus outputs float under suspend or when not bus master.
// - Processor number 001 uses line one; 000 means single processor.
// - Rotating select high rotating, low fixed priority.
module ext_bus_ctrl #(
   parameter int NUM_REQ = `NUM_MP_REQ
) (
   // Clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   rst,
   // Configuration
   input  wire logic [`PROC_NUM_W-1:0] processor_number,
   input  wire logic                   rotating_priority_select,
   input  wire logic                   ready_drive_mode_bit,
   // Core side
   input  wire logic                   ext_access_req,
   input  wire logic                   slave_access_busy,
   input  wire logic                   host_access_busy,
   // Host pins, active low
   input  wire logic                   host_bus_request_n,
   input  wire logic                   host_chip_select_n,
   input  wire logic                   suspend_bus_tristate_n,
   input  wire logic                   host_bus_grant_n_in,
   output logic                        host_bus_grant_n_out,
   output logic                        host_bus_grant_oe,
   output logic                        host_wait_ready_out,
   output logic                        host_wait_ready_oe,
   // Acknowledge pin
   input  wire logic                   ack_in,
   output logic                        ack_out,
   output logic                        ack_oe,
   // Multiprocessor request lines, active low
   input  wire logic [NUM_REQ-1:0]     mp_bus_request_lines_n_in,
   output logic                        own_bus_request_line_n_out,
   output logic [NUM_REQ-1:0]          own_bus_request_line_oe,
   // Bus and core status
   output logic                        bus_oe,
   output logic                        ext_access_done,
   output logic                        ext_access_stall
);
   if (NUM_REQ != `NUM_MP_REQ) begin : g_num_req_check
      $error("NUM_REQ must be six.");
   end

   // ******************************
   // State
   // ******************************
   typedef struct packed {
      ext_bus_pkg::bus_state_e st;
      logic [NUM_REQ-1:0]      last_owner;
      logic                    ack_keep;
      logic                    req_n;
      logic                    done;
      logic [NUM_REQ-1:0]      line_oe;
      ext_bus_pkg::pin_out_s   po;
   } state_s;

   state_s cur;
   state_s next_cur;

   logic               single;
   logic [NUM_REQ-1:0] own_bit;
   logic [NUM_REQ-1:0] reqs;
   logic [NUM_REQ-1:0] winner;
   logic               host_req;
   logic               suspend;
   logic               win;
   logic               slave_drive;

   always_comb begin
      single  = (processor_number == `PROC_NUM_SINGLE);
      own_bit = '0;
      if (!single && processor_number <= 3'(NUM_REQ)) begin
         own_bit[processor_number - 3'h1] = 1'b1;
      end
      reqs = ~mp_bus_request_lines_n_in;
      if (!cur.req_n) begin
         reqs = reqs | own_bit;
      end
      host_req = !host_bus_request_n;
      suspend  = !suspend_bus_tristate_n;
   end

   mp_priority #(
      .N(NUM_REQ)
   ) u_prio (
      .req       (reqs),
      .last_owner(cur.last_owner),
      .rotate    (rotating_priority_select),
      .winner    (winner)
   );

   assign win = single || ((winner & own_bit) != '0);

   // ******************************
   // Next state
   // ******************************
   always_comb begin
      next_cur      = cur;
      next_cur.done = 1'b0;
      case (cur.st)
         ext_bus_pkg::ST_IDLE: begin
            if (ext_access_req && !host_req) begin
               next_cur.req_n = single;
               next_cur.st    = ext_bus_pkg::ST_REQ;
            end else if (host_req && single) begin
               next_cur.st = ext_bus_pkg::ST_RELEASE;
            end
         end
         ext_bus_pkg::ST_REQ: begin
            if (host_req) begin
               next_cur.req_n = 1'b1;
               next_cur.st    = ext_bus_pkg::ST_IDLE;
            end else if (win) begin
               next_cur.st = ext_bus_pkg::ST_MASTER;
               if (!single) begin
                  next_cur.last_owner = own_bit;
               end
            end
         end
         ext_bus_pkg::ST_MASTER: begin
            if (host_req) begin
               next_cur.st = ext_bus_pkg::ST_RELEASE;
            end else if (ext_access_req && !suspend && ack_in
               && cur.po.bus_oe) begin
               next_cur.done  = 1'b1;
               next_cur.req_n = 1'b1;
               next_cur.st    = ext_bus_pkg::ST_IDLE;
            end else if (!ext_access_req) begin
               next_cur.req_n = 1'b1;
               next_cur.st    = ext_bus_pkg::ST_IDLE;
            end
         end
         ext_bus_pkg::ST_RELEASE: begin
            next_cur.st = ext_bus_pkg::ST_HOSTGNT;
         end
         ext_bus_pkg::ST_HOSTGNT: begin
            if (!host_req) begin
               next_cur.st = ext_access_req ? ext_bus_pkg::ST_REQ
                                            : ext_bus_pkg::ST_IDLE;
            end
         end
         default: begin
            next_cur.st = ext_bus_pkg::ST_IDLE;
         end
      endcase
      // Pin outputs, all registered.
      slave_drive = slave_access_busy
         && (next_cur.st != ext_bus_pkg::ST_MASTER);
      if (slave_drive) begin
         next_cur.ack_keep = !slave_access_busy;
      end else if (cur.st == ext_bus_pkg::ST_MASTER) begin
         next_cur.ack_keep = ack_in;
      end
      next_cur.po.req_oe    = !single;
      next_cur.line_oe      = next_cur.po.req_oe ? own_bit : '0;
      next_cur.po.grant_out = !(next_cur.st == ext_bus_pkg::ST_HOSTGNT);
      next_cur.po.grant_oe  = (next_cur.st == ext_bus_pkg::ST_MASTER)
         || (next_cur.st == ext_bus_pkg::ST_RELEASE)
         || (next_cur.st == ext_bus_pkg::ST_HOSTGNT);
      next_cur.po.bus_oe    = (next_cur.st == ext_bus_pkg::ST_MASTER)
         && !suspend;
      next_cur.po.ack_out   = next_cur.ack_keep;
      next_cur.po.ack_oe    = slave_drive
         || (next_cur.st == ext_bus_pkg::ST_MASTER);
      next_cur.po.ready_out = !host_access_busy;
      next_cur.po.ready_oe  = host_req && !host_chip_select_n
         && (ready_drive_mode_bit || host_access_busy);
      next_cur.po.stall     = ext_access_req && suspend
         && !next_cur.done;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cur            <= '0;
         cur.st         <= ext_bus_pkg::ST_IDLE;
         cur.last_owner <= NUM_REQ'(1);
         cur.req_n      <= 1'b1;
         cur.ack_keep   <= 1'b1;
         cur.po.grant_out <= 1'b1;
         cur.po.ack_out   <= 1'b1;
         cur.po.ready_out <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   // ******************************
   // Outputs
   // ******************************
   assign host_bus_grant_n_out       = cur.po.grant_out;
   assign host_bus_grant_oe          = cur.po.grant_oe;
   assign host_wait_ready_out        = cur.po.ready_out;
   assign host_wait_ready_oe         = cur.po.ready_oe;
   assign ack_out                    = cur.po.ack_out;
   assign ack_oe                     = cur.po.ack_oe;
   assign own_bus_request_line_n_out = cur.req_n;
   assign own_bus_request_line_oe    = cur.line_oe;
   assign bus_oe                     = cur.po.bus_oe;
   assign ext_access_done            = cur.done;
   assign ext_access_stall           = cur.po.stall;

   // ******************************
   // Checks
   // ******************************
   a_bus_float: assert property (
      @(posedge core_clk) disable iff (rst)
      !suspend_bus_tristate_n |=> !bus_oe)
      else $error("Bus driven after suspend.");
   a_float_slave: assert property (
      @(posedge core_clk) disable iff (rst)
      bus_oe |-> cur.st == ext_bus_pkg::ST_MASTER)
      else $error("Bus driven while not master.");
   sequence s_release;
      host_bus_request_n ##1 !host_bus_request_n;
   endsequence
   a_grant_after: assert property (
      @(posedge core_clk) disable iff (rst)
      (!host_bus_grant_n_out && host_bus_grant_oe) |-> $past(!bus_oe))
      else $error("Grant before bus release.");
   a_grant_hold: assert property (
      @(posedge core_clk) disable iff (rst)
      (!host_bus_grant_n_out && !host_bus_request_n) |=>
      !host_bus_grant_n_out)
      else $error("Grant dropped while requested.");
   a_grant_drv: assert property (
      @(posedge core_clk) disable iff (rst)
      !host_bus_grant_n_out |-> host_bus_grant_oe)
      else $error("Grant asserted but not driven.");
   a_ready_gate: assert property (
      @(posedge core_clk) disable iff (rst)
      host_wait_ready_oe |-> $past(!host_chip_select_n
      && !host_bus_request_n))
      else $error("Ready driven without select.");
   a_ready_low: assert property (
      @(posedge core_clk) disable iff (rst)
      (host_access_busy && !host_chip_select_n && !host_bus_request_n)
      |=> host_wait_ready_oe && !host_wait_ready_out)
      else $error("Ready not pulled low.");
   a_ack_wait: assert property (
      @(posedge core_clk) disable iff (rst)
      ext_access_done |-> $past(ack_in) && $past(suspend_bus_tristate_n))
      else $error("Access finished under wait.");
   a_done_driven: assert property (
      @(posedge core_clk) disable iff (rst)
      ext_access_done |-> $past(bus_oe))
      else $error("Access finished with bus floating.");
   a_host_first: assert property (
      @(posedge core_clk) disable iff (rst)
      s_release |=> ##1 cur.st != ext_bus_pkg::ST_MASTER
      || $past(cur.st) == ext_bus_pkg::ST_MASTER)
      else $error("Host did not win.");
   a_own_line: assert property (
      @(posedge core_clk) disable iff (rst)
      $onehot0(own_bus_request_line_oe)
      && (cur.po.req_oe || own_bus_request_line_oe == '0))
      else $error("More than one request line driven.");
endmodule
`default_nettype wire

// file: dv/host_partner.sv
// Host processor and external memory model for the bus control block.
// Assumes the bench resolves the grant and acknowledge wires.
`timescale 1ns/1ps
`default_nettype none
module host_partner (
   // Clock and bench controls
   input  wire logic core_clk,
   input  wire logic host_want,
   input  wire logic select_want,
   input  wire logic access_req,
   input  wire logic [31:0] wait_cycles,
   // Pins
   input  wire logic host_bus_grant_n,
   output logic      host_bus_request_n,
   output logic      host_chip_select_n,
   output logic      mem_ack,
   output logic      host_owns_bus
);
   // **********************************************************
   // Host handshake and memory wait states
   // **********************************************************
   int cnt = 0;
   initial begin
      host_bus_request_n = 1'b1;
      host_chip_select_n = 1'b1;
      host_owns_bus = 1'b0;
   end
   assign mem_ack = !(access_req && cnt < int'(wait_cycles));
   always @(posedge core_clk) begin
      cnt <= access_req ? cnt + 1 : 0;
   end
   always @(negedge core_clk) begin
      host_bus_request_n <= !host_want;
      host_chip_select_n <= !select_want;
      host_owns_bus <= !host_bus_request_n && !host_bus_grant_n;
   end
endmodule
`default_nettype wire

// file: dv/external_bus_host_handshake_bench.sv
// Self-checking bench for the external bus control block.
// Assumes the host partner model and a pull-up on unused request lines.
`timescale 1ns/1ps
`default_nettype none
module external_bus_host_handshake_bench;
   // **********************************************************
   // Signals and wires
   // **********************************************************
   logic       core_clk = 1'b0;
   logic       rst      = 1'b1;
   logic [2:0] pnum     = 3'h0;
   logic       rot_sel  = 1'b0;
   logic       mode     = 1'b0;
   logic       req      = 1'b0;
   logic       slv      = 1'b0;
   logic       hbusy    = 1'b0;
   logic       susp_n   = 1'b1;
   logic       hwant    = 1'b0;
   logic       swant    = 1'b0;
   int         waitc    = 0;
   int         err_count = 0;
   int         checks   = 0;
   int         n;
   logic       g_out, g_oe, r_out, r_oe, a_out, a_oe, own_n, bus_oe;
   logic       done, stall, hreq_n, cs_n, mem_ack, howns;
   logic [5:0] own_oe;
   logic [5:0] peer_n   = 6'h3F;
   wire  logic g_n      = g_oe ? g_out : 1'b1;
   wire  logic ack_in   = req ? mem_ack : (a_oe ? a_out : 1'b1);
   wire  logic [5:0] mp_n = peer_n & ~(own_oe & {6{~own_n}});
   always #12.5 core_clk = ~core_clk;
   ext_bus_ctrl dut (.core_clk(core_clk), .rst(rst),
      .processor_number(pnum), .rotating_priority_select(rot_sel),
      .ready_drive_mode_bit(mode), .ext_access_req(req),
      .slave_access_busy(slv), .host_access_busy(hbusy),
      .host_bus_request_n(hreq_n), .host_chip_select_n(cs_n),
      .suspend_bus_tristate_n(susp_n), .host_bus_grant_n_in(g_n),
      .host_bus_grant_n_out(g_out), .host_bus_grant_oe(g_oe),
      .host_wait_ready_out(r_out), .host_wait_ready_oe(r_oe),
      .ack_in(ack_in), .ack_out(a_out), .ack_oe(a_oe),
      .mp_bus_request_lines_n_in(mp_n), .own_bus_request_line_n_out(own_n),
      .own_bus_request_line_oe(own_oe), .bus_oe(bus_oe),
      .ext_access_done(done), .ext_access_stall(stall));
   host_partner host (.core_clk(core_clk), .host_want(hwant),
      .select_want(swant), .access_req(req), .wait_cycles(waitc),
      .host_bus_grant_n(g_n), .host_bus_request_n(hreq_n),
      .host_chip_select_n(cs_n), .mem_ack(mem_ack), .host_owns_bus(howns));
   // **********************************************************
   // Tasks
   // **********************************************************
   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test();
      if (err_count == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic tick(int c);
      repeat (c) @(posedge core_clk);
      #1;
   endtask
   task automatic reset(int c);
      @(negedge core_clk);
      rst <= 1'b1;
      repeat (c) @(negedge core_clk);
      rst <= 1'b0;
   endtask
   task automatic access(int w, int s);
      int   exp;
      logic oe_prev;
      exp = (s + 2 > 3) ? s + 2 : 3;
      if (w + 1 > exp) exp = w + 1;
      oe_prev = 1'b0;
      @(negedge core_clk);
      waitc = w;
      susp_n <= (s == 0);
      req <= 1'b1;
      for (n = 1; n <= 40; n++) begin
         tick(1);
         if (done === 1'b1) break;
         if (n == 1) check("stall", stall, 8'(s > 0));
         oe_prev = bus_oe;
         @(negedge core_clk);
         if (n >= s) susp_n <= 1'b1;
      end
      if (n > 40) begin
         err_count++;
         end_of_test();
      end
      check("access cycles", 8'(n), 8'(exp));
      check("suspend stall", n > s, 8'h01);
      check("bus_oe before done", oe_prev, 8'h01);
      @(negedge core_clk);
      req <= 1'b0;
   endtask
   // **********************************************************
   // Invariant monitor and main sequence
   // **********************************************************
   always @(posedge core_clk) begin
      #1;
      if (rst === 1'b0) begin
         if (susp_n === 1'b0) check("bus_oe suspended", bus_oe, 8'h00);
         if (g_oe === 1'b1 && g_out === 1'b0) begin
            check("request under grant", hreq_n, 8'h00);
            check("bus_oe under grant", bus_oe, 8'h00);
         end
         if (r_oe === 1'b1) check("ready qual", {cs_n, hreq_n}, 8'h00);
         if (r_oe === 1'b1 && mode === 1'b0) check("ready od", r_out, 8'h00);
      end
   end
   initial begin
      void'($urandom(13412));
      reset(20);
      tick(1);
      check("grant_oe reset", g_oe, 8'h00);
      check("bus_oe reset", bus_oe, 8'h00);
      repeat (6) access($urandom_range(3, 0), $urandom_range(2, 0));
      @(negedge core_clk);
      req <= 1'b1;
      hwant <= 1'b1;
      for (n = 0; n < 20 && howns !== 1'b1; n++) tick(1);
      check("host granted", howns, 8'h01);
      if (n >= 20) end_of_test();
      @(negedge core_clk);
      swant <= 1'b1;
      hbusy <= 1'b1;
      tick(2);
      check("done under host", done, 8'h00);
      check("ready wait", {r_oe, r_out}, 8'h02);
      @(negedge core_clk);
      mode <= 1'b1;
      hbusy <= 1'b0;
      tick(2);
      check("ready drive", {r_oe, r_out}, 8'h03);
      @(negedge core_clk);
      swant <= 1'b0;
      hwant <= 1'b0;
      access(0, 0);
      @(negedge core_clk);
      slv <= 1'b1;
      tick(2);
      check("slave ack", {a_oe, a_out}, 8'h02);
      @(negedge core_clk);
      slv <= 1'b0;
      for (int k = 1; k <= 6; k++) begin
         pnum <= 3'(k);
         rot_sel <= 1'($urandom);
         reset(2);
         access($urandom_range(2, 0), 0);
         check("own line", own_oe, 8'h01 << (k - 1));
      end
      end_of_test();
   end
endmodule
`default_nettype wire
